// File: core/pag_port_a.sv
// Behaviour
// - Eight-bit output latch, one bit per pin.
// - Pin four: open-drain driver, timer clock input.
// - Pin five is input only, never driven.
// - Other pins have push-pull outputs.
// - Direction one floats pin, zero drives latch.
// - Reads return pin levels, writes load latch.
// - Set and clear writes sample pins, modify bits, store latch.
// - Comparator and reference controls select pin functions.
// - Comparator input pins read as zero.
// - High voltage on pin five enters programming.
// - Reset: all inputs, comparator inputs grounded.
// - Oscillator pins ignore direction, read zero.
// - Comparator output mode drives pins three, four.
// - Enabled peripheral takes pin from general use; direction bits still steer analog and comparator output pins.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pag_port_a
(
  input  wire  logic                       clk,
  input  wire  logic                       rstn,
  input  wire  logic [pag_pkg::ADDR_W-1:0] paddr,
  input  wire  logic                       psel,
  input  wire  logic                       penable,
  input  wire  logic                       pwrite,
  input  wire  logic [pag_pkg::DATA_W-1:0] pwdata,
  output logic       [pag_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire  logic [7:0]                 padIn,
  output logic       [7:0]                 padOut,
  output logic       [7:0]                 padOe,
  input  wire  logic                       cmp1Out,
  input  wire  logic                       cmp2Out,
  input  wire  logic [1:0]                 oscClaim,
  input  wire  logic                       pin5HighVolt,
  output logic                             progMode,
  output logic                             timer0ExtClk,
  output logic       [2:0]                 cmpMode,
  output logic       [1:0]                 cmpInvert,
  output logic                             cmpInputSelect,
  output logic                             cmpInForceGnd,
  output logic                             vrefEnable,
  output logic                             vrefOutEnable,
  output logic                             vrefRange,
  output logic       [3:0]                 vrefLevel
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Pins that the comparator and reference take as analog pins.
  function automatic logic [7:0] analogPins(input logic [2:0] mode,
                                            input logic       vrefOut);
    logic [7:0] m;
    m = pag_pkg::ANA_ALL4;
    case (mode)
      pag_pkg::CM_OFF:     m = pag_pkg::ANA_NONE;
      pag_pkg::CM_OUTPUTS: m = pag_pkg::ANA_LOW3;
      default:             m = pag_pkg::ANA_ALL4;
    endcase
    if (vrefOut)
    begin
      m[pag_pkg::PIN_VREF] = 1'b1;
    end
    return m;
  endfunction

  // True when a byte address hits the given register index.
  function automatic logic hits(input logic [pag_pkg::ADDR_W-1:0] a,
                                input logic [7:0]                 idx);
    return a == {idx, 2'b00};
  endfunction

  // ****************************************************************
  // Registers and decode.
  // ****************************************************************
  logic [7:0] latchQ;     // Output latch.
  logic [7:0] dirQ;       // Direction bits, 1 means input.
  logic [7:0] cmpCtlQ;    // Comparator control, writable part.
  logic [7:0] vrefCtlQ;   // Reference control.
  logic [7:0] rdByteQ;    // Read data captured in the setup phase.
  logic       errQ;       // Unmapped address seen in setup.
  logic       progModeQ;  // Programming mode entered.
  logic       t0ClkQ;     // Timer 0 clock level.
  logic [7:0] pinRead;    // Gated pin levels.
  logic [7:0] anaMask;    // Pins in analog use.
  logic       setup;      // APB setup phase.
  logic       access;     // APB access phase.
  logic       wrEn;       // Write takes effect this edge.
  logic       mapped;     // Address hits a register.
  logic [7:0] wByte;      // Low byte of the write data.
  logic       cmpOutMode; // Comparator results go to pins 3 and 4.

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wByte  = pwdata[7:0];
  assign mapped = hits(paddr, pag_pkg::IDX_DATA) ||
                  hits(paddr, pag_pkg::IDX_DIR)  ||
                  hits(paddr, pag_pkg::IDX_CMP)  ||
                  hits(paddr, pag_pkg::IDX_VREF) ||
                  hits(paddr, pag_pkg::IDX_SET)  ||
                  hits(paddr, pag_pkg::IDX_CLR);
  // A refused write changes nothing.
  assign wrEn   = access && pwrite && mapped;

  // The slave never stalls; the read byte was caught during setup.
  assign pready  = 1'b1;
  assign pslverr = access && errQ;
  assign prdata  = {24'h000000, rdByteQ};

  // ****************************************************************
  // Pin function selection.
  // ****************************************************************
  assign anaMask = analogPins(cmpCtlQ[pag_pkg::CM_LSB +: 3],
                              vrefCtlQ[pag_pkg::VROE_BIT]);
  assign cmpOutMode = cmpCtlQ[pag_pkg::CM_LSB +: 3] == pag_pkg::CM_OUTPUTS;

  // One cell per pin; the driver style is fixed by the pin number.
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    localparam pag_pkg::pag_drv_t KIND =
      (i == pag_pkg::PIN_OD) ? pag_pkg::PAG_DRV_OPEN_DRAIN :
      (i == pag_pkg::PIN_HV) ? pag_pkg::PAG_DRV_INPUT_ONLY :
                               pag_pkg::PAG_DRV_PUSHPULL;
    pag_pkg::pag_pin_ctl_t ctl;  // Control bundle of this pin.
    pag_pkg::pag_pad_t     pad;  // Driver of this pin.
    // Comparator outputs replace the latch only in their own mode, so
    // a peripheral pin leaves general-purpose use.
    assign ctl.latch    = latchQ[i];
    assign ctl.dirInput = dirQ[i];
    assign ctl.altEn    = cmpOutMode && (i == pag_pkg::PIN_CMP1 ||
                                         i == pag_pkg::PIN_OD);
    assign ctl.altVal   = (i == pag_pkg::PIN_OD) ? cmp2Out : cmp1Out;
    assign ctl.analog   = anaMask[i];
    assign ctl.oscClaim = (i == pag_pkg::PIN_OSC2) ? oscClaim[0] :
                          (i == pag_pkg::PIN_OSC1) ? oscClaim[1] : 1'b0;
    pag_pin_cell #(.KIND(KIND)) u_cell
    (
      .ctl     (ctl),
      .padIn   (padIn[i]),
      .pad     (pad),
      .readBit (pinRead[i])
    );
    assign padOut[i] = pad.out;
    assign padOe[i]  = pad.oe;
  end

  // ****************************************************************
  // Bus read side.
  // ****************************************************************
  // Read data is captured in the setup cycle, so the data output
  // comes from a flip-flop without adding a wait state.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdByteQ <= 8'h00;
      errQ    <= 1'b0;
    end
    else if (setup)
    begin
      errQ <= !mapped;
      if (hits(paddr, pag_pkg::IDX_DATA))
      begin
        rdByteQ <= pinRead;
      end
      else if (hits(paddr, pag_pkg::IDX_DIR))
      begin
        rdByteQ <= dirQ;
      end
      else if (hits(paddr, pag_pkg::IDX_CMP))
      begin
        // Comparator results are live status, the rest is control.
        rdByteQ <= {cmp2Out, cmp1Out, cmpCtlQ[5:0]};
      end
      else if (hits(paddr, pag_pkg::IDX_VREF))
      begin
        rdByteQ <= vrefCtlQ;
      end
      else
      begin
        // Set and clear strobes and unmapped addresses read zero.
        rdByteQ <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Output latch.
  // ****************************************************************
  // Set and clear writes start from the sampled pin levels, not from the
  // latch, so a pin held low from outside can flip its latch bit.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      latchQ <= pag_pkg::DATA_RST;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_DATA))
    begin
      latchQ <= wByte;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_SET))
    begin
      latchQ <= pinRead | wByte;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_CLR))
    begin
      latchQ <= pinRead & ~wByte;
    end
  end

  // ****************************************************************
  // Direction and function control.
  // ****************************************************************
  // Direction bits keep steering the drivers in analog modes too.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dirQ <= pag_pkg::DIR_RST;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_DIR))
    begin
      dirQ <= wByte;
    end
  end

  // Reset leaves the comparators in the grounded-input mode.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cmpCtlQ  <= pag_pkg::CMP_RST;
      vrefCtlQ <= pag_pkg::VREF_RST;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_CMP))
    begin
      cmpCtlQ <= wByte & pag_pkg::CMP_WMASK;
    end
    else if (wrEn && hits(paddr, pag_pkg::IDX_VREF))
    begin
      vrefCtlQ <= wByte & pag_pkg::VREF_WMASK;
    end
  end

  assign cmpMode        = cmpCtlQ[pag_pkg::CM_LSB +: 3];
  assign cmpInvert      = {cmpCtlQ[pag_pkg::C2INV], cmpCtlQ[pag_pkg::C1INV]};
  assign cmpInputSelect = cmpCtlQ[pag_pkg::CIS_BIT];
  assign cmpInForceGnd  = cmpMode == pag_pkg::CM_RESET;
  assign vrefEnable     = vrefCtlQ[pag_pkg::VREN_BIT];
  assign vrefOutEnable  = vrefCtlQ[pag_pkg::VROE_BIT];
  assign vrefRange      = vrefCtlQ[pag_pkg::VRR_BIT];
  assign vrefLevel      = vrefCtlQ[pag_pkg::VR_LSB +: 4];

  // ****************************************************************
  // Pin five and pin four side functions.
  // ****************************************************************
  // Programming mode follows the high-voltage detector; the port
  // keeps working normally while it is set.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      progModeQ <= 1'b0;
    end
    else
    begin
      progModeQ <= pin5HighVolt;
    end
  end

  // The timer clock taps the Schmitt input directly, so it still
  // counts while the pin also drives as a comparator output.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      t0ClkQ <= 1'b0;
    end
    else
    begin
      t0ClkQ <= padIn[pag_pkg::PIN_OD];
    end
  end

  assign progMode     = progModeQ;
  assign timer0ExtClk = t0ClkQ;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_dir_after_reset: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> dirQ == 8'hFF && cmpInForceGnd)
    else $error("Direction or comparator mode wrong after reset.");

  a_pin5_never_driven: assert property (
    @(posedge clk) disable iff (!rstn)
    !padOe[5])
    else $error("Pin five is driven.");

  a_pin4_open_drain: assert property (
    @(posedge clk) disable iff (!rstn)
    padOe[4] |-> !padOut[4] && !dirQ[4])
    else $error("Pin four drives high or without direction.");

  a_dir_input_floats: assert property (
    @(posedge clk) disable iff (!rstn)
    dirQ[0] |-> !padOe[0])
    else $error("Input pin zero is driven.");

  a_dir_output_drives: assert property (
    @(posedge clk) disable iff (!rstn)
    !dirQ[1] |-> padOe[1] && padOut[1] == latchQ[1])
    else $error("Output pin one not driving its latch.");

  a_data_write_latch: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pwrite && hits(paddr, pag_pkg::IDX_DATA)
      |=> latchQ == $past(pwdata[7:0]) && padOut[0] == $past(pwdata[0]))
    else $error("Data write did not reach the latch.");

  a_rmw_set_bits: assert property (
    @(posedge clk) disable iff (!rstn)
    access && pwrite && hits(paddr, pag_pkg::IDX_SET)
      |=> latchQ == ($past(pinRead) | $past(pwdata[7:0])))
    else $error("Bit set did not start from pin levels.");

  a_read_pin_levels: assert property (
    @(posedge clk) disable iff (!rstn)
    setup && !pwrite && hits(paddr, pag_pkg::IDX_DATA)
      |=> prdata[7:0] == $past(pinRead) ##0 pready)
    else $error("Port read did not return pin levels.");

  a_analog_reads_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    cmpMode != pag_pkg::CM_OFF |-> pinRead[3:0] == 4'h0 ||
      cmpMode == pag_pkg::CM_OUTPUTS && pinRead[2:0] == 3'h0)
    else $error("Comparator input pin reads non-zero.");

  a_osc_claim_pins: assert property (
    @(posedge clk) disable iff (!rstn)
    oscClaim == 2'h3 |-> padOe[7:6] == 2'h0 && pinRead[7:6] == 2'h0)
    else $error("Oscillator pins not overridden.");

  a_prog_entry: assert property (
    @(posedge clk) disable iff (!rstn)
    pin5HighVolt ##1 pin5HighVolt |-> progMode)
    else $error("Programming mode not entered.");

  a_cmp_output_pin: assert property (
    @(posedge clk) disable iff (!rstn)
    cmpOutMode && !dirQ[3] |-> padOe[3] && padOut[3] == cmp1Out)
    else $error("Comparator 1 result not on pin three.");

endmodule
`default_nettype wire

// File: core/pag_pkg.sv
// ****************************************************************
// Shared constants and types of the port A pin logic.
// ****************************************************************
`default_nettype none
package pag_pkg;

  // ****************************************************************
  // Register bus geometry.
  // ****************************************************************
  localparam int unsigned ADDR_W = 10;  // Byte address width on APB.
  localparam int unsigned DATA_W = 32;  // APB data width.
  localparam int unsigned PINS   = 8;   // Pins on the port.

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_DATA = 8'h05;  // Port data register.
  localparam logic [7:0] IDX_DIR  = 8'h85;  // Direction register.
  localparam logic [7:0] IDX_CMP  = 8'h1F;  // Comparator control.
  localparam logic [7:0] IDX_VREF = 8'h9F;  // Voltage reference control.
  localparam logic [7:0] IDX_SET  = 8'hE5;  // Read-modify-write bit set.
  localparam logic [7:0] IDX_CLR  = 8'hE6;  // Read-modify-write bit clear.

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [7:0] DATA_RST = 8'h00;  // Output latch.
  localparam logic [7:0] DIR_RST  = 8'hFF;  // All pins are inputs.
  localparam logic [7:0] CMP_RST  = 8'h00;  // Comparators in reset.
  localparam logic [7:0] VREF_RST = 8'h00;  // Reference off.

  // ****************************************************************
  // Field positions of the comparator and reference controls.
  // ****************************************************************
  localparam int unsigned CM_LSB   = 0;  // Comparator mode, 3 bits.
  localparam int unsigned CIS_BIT  = 3;  // Comparator input select.
  localparam int unsigned C1INV    = 4;  // Comparator 1 invert.
  localparam int unsigned C2INV    = 5;  // Comparator 2 invert.
  localparam int unsigned C1OUT    = 6;  // Comparator 1 result.
  localparam int unsigned C2OUT    = 7;  // Comparator 2 result.
  localparam int unsigned VR_LSB   = 0;  // Reference level, 4 bits.
  localparam int unsigned VRR_BIT  = 5;  // Reference range.
  localparam int unsigned VROE_BIT = 6;  // Reference output on pin 2.
  localparam int unsigned VREN_BIT = 7;  // Reference enable.
  localparam logic [7:0]  CMP_WMASK  = 8'h3F;  // Result bits read only.
  localparam logic [7:0]  VREF_WMASK = 8'hEF;  // Bit 4 is unused.

  // Comparator modes that the port logic must tell apart.
  localparam logic [2:0] CM_RESET   = 3'h0;  // Inputs grounded.
  localparam logic [2:0] CM_OUTPUTS = 3'h6;  // Results on pins 3 and 4.
  localparam logic [2:0] CM_OFF     = 3'h7;  // All pins digital.

  // Analog input masks per comparator mode.
  localparam logic [7:0] ANA_ALL4   = 8'h0F;  // Pins 0 to 3.
  localparam logic [7:0] ANA_LOW3   = 8'h07;  // Pins 0 to 2.
  localparam logic [7:0] ANA_NONE   = 8'h00;  // No analog pins.

  // Pin numbers with special roles.
  localparam int unsigned PIN_VREF = 2;  // Reference output.
  localparam int unsigned PIN_CMP1 = 3;  // Comparator 1 output.
  localparam int unsigned PIN_OD   = 4;  // Open drain, timer clock.
  localparam int unsigned PIN_HV   = 5;  // Input only, programming.
  localparam int unsigned PIN_OSC2 = 6;  // Oscillator output side.
  localparam int unsigned PIN_OSC1 = 7;  // Oscillator input side.

  // ****************************************************************
  // Types.
  // ****************************************************************
  // Output driver style of one pin.
  typedef enum logic [1:0]
  {
    PAG_DRV_PUSHPULL,
    PAG_DRV_OPEN_DRAIN,
    PAG_DRV_INPUT_ONLY
  } pag_drv_t;

  // Everything a pin cell needs from the port registers.
  typedef struct packed
  {
    logic latch;     // Output latch bit.
    logic dirInput;  // Direction bit, 1 means input.
    logic altEn;     // Peripheral owns the output value.
    logic altVal;    // Peripheral output value.
    logic analog;    // Pin serves an analog function.
    logic oscClaim;  // Oscillator owns the pin.
  } pag_pin_ctl_t;

  // Output side of one pad.
  typedef struct packed
  {
    logic out;  // Level driven when enabled.
    logic oe;   // Driver enable.
  } pag_pad_t;

endpackage
`default_nettype wire

// File: core/pag_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One port pin: driver style, direction and read-back gating.
// ****************************************************************
module pag_pin_cell
#(
  parameter pag_pkg::pag_drv_t KIND = pag_pkg::PAG_DRV_PUSHPULL
)
(
  input  wire  pag_pkg::pag_pin_ctl_t ctl,
  input  wire  logic                  padIn,
  output var   pag_pkg::pag_pad_t     pad,
  output logic                        readBit
);

  logic drive;  // Pin is an output right now.
  logic value;  // Level the pin would carry.

  // The oscillator overrides the direction bit; otherwise a cleared
  // direction bit turns the driver on, also for peripheral outputs.
  assign drive = !ctl.oscClaim && !ctl.dirInput;
  assign value = ctl.altEn ? ctl.altVal : ctl.latch;

  // Driver style picks how the level reaches the wire.
  always_comb
  begin
    case (KIND)
      pag_pkg::PAG_DRV_PUSHPULL:
      begin
        pad.out = value;
        pad.oe  = drive;
      end
      pag_pkg::PAG_DRV_OPEN_DRAIN:
      begin
        // Only pulls low; a high level comes from an external pull-up.
        pad.out = 1'b0;
        pad.oe  = drive && !value;
      end
      default:
      begin
        // No driver exists, so latch and direction never reach the pin.
        pad.out = 1'b0;
        pad.oe  = 1'b0;
      end
    endcase
  end

  // Analog and oscillator pins have their digital input cut off.
  assign readBit = (ctl.analog || ctl.oscClaim) ? 1'b0 : padIn;

endmodule
`default_nettype wire

// File: tb/pag_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Board model: external drivers and pull-ups on the eight pins.
// ****************************************************************
module pag_pad_model
(
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  output logic      [7:0] padIn
);
  // Every pin has a pull-up, so a released line never keeps its old
  // value. The open-drain pin needs it to read high. The bench drives
  // a pin only while it is an input: comparator inputs and the
  // reference pin get no load of their own.
  always_comb
  begin
    padIn = (padOe & padOut) | (~padOe & ((extEn & extVal) | ~extEn));
  end
endmodule
`default_nettype wire

// File: tb/pag_port_a_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pag_port_a_tb;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic       pready;
  logic       pslverr;
  logic [7:0] padIn;
  logic [7:0] padOut;
  logic [7:0] padOe;
  logic [7:0] extEn = 8'hFF;
  logic [7:0] extVal = 8'hFF;
  logic       cmp1Out = 1'b0;
  logic       cmp2Out = 1'b0;
  logic [1:0] oscClaim = 2'h0;
  logic       pin5HighVolt = 1'b0;
  logic       progMode;
  logic       timer0ExtClk;
  logic [2:0] cmpMode;
  logic       cmpInForceGnd;
  logic       vrefEnable;
  logic       vrefOutEnable;
  logic [1:0] cmpInvert;
  logic       cmpInputSelect;
  logic       vrefRange;
  logic [3:0] vrefLevel;
  logic [7:0] rdQ;
  logic       errQ;
  int         fails = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // The clock runs at 100 MHz.
  always #5 clk = ~clk;

  pag_port_a pag_port_a_inst
  (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .cmp1Out(cmp1Out), .cmp2Out(cmp2Out), .oscClaim(oscClaim),
    .pin5HighVolt(pin5HighVolt), .progMode(progMode),
    .timer0ExtClk(timer0ExtClk), .cmpMode(cmpMode),
    .cmpInvert(cmpInvert), .cmpInputSelect(cmpInputSelect),
    .cmpInForceGnd(cmpInForceGnd),
    .vrefEnable(vrefEnable), .vrefOutEnable(vrefOutEnable),
    .vrefRange(vrefRange), .vrefLevel(vrefLevel)
  );

  pag_pad_model pag_pad_model_inst
  (
    .padOut(padOut), .padOe(padOe), .extEn(extEn), .extVal(extVal),
    .padIn(padIn)
  );

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  // Ends the run; the only place that prints the verdict.
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compares one byte with case equality, so an unknown never matches.
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= {idx, 2'h0};
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdQ = prdata[7:0];
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] idx,
                    input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    check(nm, e, rdQ);
  endtask

  // The wait is cut short well above the length of the sequence.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd("dir", pag_pkg::IDX_DIR, 8'hFF);
    check("oe", 8'h00, padOe);
    check("gnd", 8'h01, {7'h00, cmpInForceGnd});
    rd("data", pag_pkg::IDX_DATA, 8'hF0);
    apb(1'b1, pag_pkg::IDX_CMP, 8'h07);
    rd("cmp", pag_pkg::IDX_CMP, 8'h07);
    apb(1'b1, pag_pkg::IDX_DATA, 8'h5A);
    apb(1'b1, pag_pkg::IDX_DIR, 8'h00);
    extEn <= 8'h00;
    @(negedge clk);
    check("oe", 8'hCF, padOe);
    check("out", 8'h4A, padOut & padOe);
    check("t0", 8'h01, {7'h00, timer0ExtClk});
    rd("data", pag_pkg::IDX_DATA, 8'h7A);
    // Pin 0 as input held high by the board; set and clear must take
    // it from the pins, not from the latch.
    apb(1'b1, pag_pkg::IDX_DIR, 8'h01);
    extEn <= 8'h01;
    extVal <= 8'h01;
    apb(1'b1, pag_pkg::IDX_SET, 8'h80);
    apb(1'b1, pag_pkg::IDX_CLR, 8'h0A);
    apb(1'b1, pag_pkg::IDX_DIR, 8'h00);
    extEn <= 8'h00;
    rd("rmw", pag_pkg::IDX_DATA, 8'hF1);
    apb(1'b1, pag_pkg::IDX_DIR, 8'hFF);
    extEn <= 8'hFF;
    extVal <= 8'h00;
    rd("float", pag_pkg::IDX_DATA, 8'h00);
    check("oe", 8'h00, padOe);
    check("t0", 8'h00, {7'h00, timer0ExtClk});
    extEn <= 8'h00;
    oscClaim <= 2'h3;
    apb(1'b1, pag_pkg::IDX_DATA, 8'hFF);
    apb(1'b1, pag_pkg::IDX_DIR, 8'h00);
    rd("osc", pag_pkg::IDX_DATA, 8'h3F);
    check("oe", 8'h0F, padOe);
    oscClaim <= 2'h0;
    cmp1Out <= 1'b1;
    // Pins 0 to 2 turn analog in this mode, so they go back to inputs.
    apb(1'b1, pag_pkg::IDX_DIR, 8'h07);
    apb(1'b1, pag_pkg::IDX_CMP, 8'h06);
    @(negedge clk);
    check("oe", 8'hD8, padOe);
    check("out", 8'hC8, padOut & padOe);
    check("mode", 8'h06, {5'h00, cmpMode});
    rd("data", pag_pkg::IDX_DATA, 8'hE8);
    rd("cmp", pag_pkg::IDX_CMP, 8'h46);
    apb(1'b1, pag_pkg::IDX_CMP, 8'h3F);
    apb(1'b1, pag_pkg::IDX_DIR, 8'h04);
    apb(1'b1, pag_pkg::IDX_VREF, 8'hE5);
    rd("vref", pag_pkg::IDX_VREF, 8'hE5);
    check("ven", 8'h03, {6'h00, vrefEnable, vrefOutEnable});
    check("cfg", 8'hF5,
          {cmpInvert, cmpInputSelect, vrefRange, vrefLevel});
    rd("data", pag_pkg::IDX_DATA, 8'hFB);
    // Comparator inputs on pins 0 to 3 need those pins as inputs.
    apb(1'b1, pag_pkg::IDX_DIR, 8'h0F);
    apb(1'b1, pag_pkg::IDX_CMP, 8'h00);
    rd("data", pag_pkg::IDX_DATA, 8'hF0);
    check("gnd", 8'h01, {7'h00, cmpInForceGnd});
    rd("bad", 8'h10, 8'h00);
    check("err", 8'h01, {7'h00, errQ});
    pin5HighVolt <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("prog", 8'h01, {7'h00, progMode});
    give_verdict();
  end
endmodule
`default_nettype wire
